// file: fgp_consts.svh
`ifndef FGP_CONSTS_SVH
`define FGP_CONSTS_SVH

// ----------------------------------------------------------------
// word addresses on the serial programming port
// ----------------------------------------------------------------
`define FGP_ADDR_POST_AMP 8'h33
`define FGP_ADDR_TERM 8'h34
`define FGP_ADDR_POWER 8'h35
`define FGP_ADDR_DOPPLER 8'h36
`define FGP_ADDR_CH_GAIN 8'h39

// ----------------------------------------------------------------
// reset value and frame shape
// ----------------------------------------------------------------
`define FGP_WORD_RESET 16'h0000
`define FGP_FRAME_BITS 5'h18
`define FGP_ADDR_BITS 8
`define FGP_NUM_CH 8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FGP_POST_AMP_GAIN_BIT 13
`define FGP_TERM_IND_HI 4
`define FGP_TERM_IND_LO 0
`define FGP_TERM_IND_EN_BIT 5
`define FGP_TERM_PRESET_HI 7
`define FGP_TERM_PRESET_LO 6
`define FGP_TERM_EN_BIT 8
`define FGP_CLAMP_HI 10
`define FGP_CLAMP_LO 9
`define FGP_INTEG_OFF_BIT 12
`define FGP_GAIN_HI 14
`define FGP_GAIN_LO 13
`define FGP_PER_CH_EN_BIT 15
`define FGP_PDN_MASK_HI 7
`define FGP_PDN_MASK_LO 0
`define FGP_LOW_NOISE_FIGURE_ENABLE_BIT 9
`define FGP_PMODE_HI 11
`define FGP_PMODE_LO 10
`define FGP_ATT_PDN_BIT 12
`define FGP_AMP_PDN_BIT 13
`define FGP_PARTIAL_BIT 14
`define FGP_COMPLETE_BIT 15
`define FGP_SUM_FB_HI 4
`define FGP_SUM_FB_LO 0
`define FGP_FAST_CLK_BIT 5

// ----------------------------------------------------------------
// resistor maps loaded for each preset (plain defaults)
// ----------------------------------------------------------------
`define FGP_MAP_50 5'h01
`define FGP_MAP_100 5'h02
`define FGP_MAP_200 5'h04
`define FGP_MAP_400 5'h08

`endif

// file: fgp_pkg.sv
`include "fgp_consts.svh"

package fgp_pkg;
	typedef enum logic [1:0] {gain_18db, gain_24db, gain_15db, gain_rsvd} fgp_gain_e;
	typedef enum logic [1:0] {pmode_low_noise, pmode_low_power, pmode_medium, pmode_rsvd} fgp_pmode_e;
	typedef enum logic [1:0] {clamp_auto, clamp_1v5, clamp_0v825, clamp_0v6} fgp_clamp_e;
	typedef enum logic [1:0] {term_50, term_100, term_200, term_400} fgp_preset_e;
	typedef enum logic [1:0] {stage_on, stage_partial, stage_off} fgp_stage_e;

	typedef struct packed {
		logic sclk_meta;
		logic sclk_sync;
		logic sclk_prev;
		logic sdata_meta;
		logic sdata_sync;
		logic sen_n_meta;
		logic sen_n_sync;
		logic [23:0] shift;
		logic [4:0] count;
		logic wr_valid;
		logic [7:0] wr_addr;
		logic [15:0] wr_data;
	} fgp_rx_s;

	typedef struct packed {
		logic [15:0] post_amp;
		logic [15:0] term;
		logic [15:0] power;
		logic [15:0] doppler;
		logic [15:0] ch_gain;
	} fgp_store_s;

	typedef struct packed {
		logic post_amp_gain_select;
		logic term_enable;
		logic [4:0] term_resistor_map;
		logic [7:0] term_high_z;
		fgp_clamp_e input_clamp_level;
		logic input_offset_integrator_off;
		logic [7:0][1:0] input_amp_gain;
		logic [7:0] imaging_path_power_down;
		logic [7:0] doppler_path_power_down;
		logic low_noise_figure_enable;
		fgp_pmode_e power_mode;
		fgp_stage_e input_amp_pwr;
		fgp_stage_e var_attenuator_pwr;
		fgp_stage_e post_amp_pwr;
		logic [4:0] summing_amp_feedback_select;
		logic doppler_fast_clock_type;
	} fgp_dec_s;
endpackage : fgp_pkg

// file: fgp_serial_rx.sv
`include "fgp_consts.svh"

module fgp_serial_rx (
	input wire logic clk,
	input wire logic srst,
	input wire logic spi_sclk,
	input wire logic spi_sdata,
	input wire logic spi_sen_n,
	output logic wr_valid,
	output logic [7:0] wr_addr,
	output logic [15:0] wr_data
);
	fgp_pkg::fgp_rx_s r;
	fgp_pkg::fgp_rx_s next_r;
	logic rise;

	// ----------------------------------------------------------------
	// shift in address then data, msb first, on sampled sclk rises
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.wr_valid = 1'b0;
		next_r.sclk_meta = spi_sclk;
		next_r.sclk_sync = r.sclk_meta;
		next_r.sclk_prev = r.sclk_sync;
		next_r.sdata_meta = spi_sdata;
		next_r.sdata_sync = r.sdata_meta;
		next_r.sen_n_meta = spi_sen_n;
		next_r.sen_n_sync = r.sen_n_meta;
		rise = r.sclk_sync & ~r.sclk_prev & ~r.sen_n_sync;
		if (r.sen_n_sync) begin
			next_r.count = 5'h00;
		end else if (rise && r.count != `FGP_FRAME_BITS) begin
			// clocks past the 24th are ignored until enable goes high
			next_r.shift = {r.shift[22:0], r.sdata_sync};
			next_r.count = r.count + 5'h01;
			if (r.count == `FGP_FRAME_BITS - 5'h01) begin
				next_r.wr_valid = 1'b1;
				next_r.wr_addr = r.shift[22:15];
				next_r.wr_data = {r.shift[14:0], r.sdata_sync};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			// idle the enable and the clock history so no false rise follows reset
			r.sen_n_meta <= 1'b1;
			r.sen_n_sync <= 1'b1;
			r.sclk_prev <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign wr_valid = r.wr_valid;
	assign wr_addr = r.wr_addr;
	assign wr_data = r.wr_data;
endmodule : fgp_serial_rx

// file: fgp_reg_store.sv
`include "fgp_consts.svh"

module fgp_reg_store (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_valid,
	input wire logic [7:0] wr_addr,
	input wire logic [15:0] wr_data,
	output logic [15:0] word_post_amp,
	output logic [15:0] word_term,
	output logic [15:0] word_power,
	output logic [15:0] word_doppler,
	output logic [15:0] word_ch_gain
);
	fgp_pkg::fgp_store_s r;
	fgp_pkg::fgp_store_s next_r;

	// ----------------------------------------------------------------
	// whole-word writes; other addresses belong to other banks
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		if (wr_valid) begin
			unique case (wr_addr)
				`FGP_ADDR_POST_AMP: next_r.post_amp = wr_data;
				`FGP_ADDR_TERM: next_r.term = wr_data;
				`FGP_ADDR_POWER: next_r.power = wr_data;
				`FGP_ADDR_DOPPLER: next_r.doppler = wr_data;
				`FGP_ADDR_CH_GAIN: next_r.ch_gain = wr_data;
				default: next_r = r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= {5{`FGP_WORD_RESET}};
		end else begin
			r <= next_r;
		end
	end

	assign word_post_amp = r.post_amp;
	assign word_term = r.term;
	assign word_power = r.power;
	assign word_doppler = r.doppler;
	assign word_ch_gain = r.ch_gain;
endmodule : fgp_reg_store

// file: fgp_front_end_cfg.sv
// Notes on behaviour
// [R01] individual resistor field applies only when enabled
// [R02] preset code picks 50/100/200/400 ohm map
// [R03] preset 00 at 15 dB means high impedance
// [R04] termination enable bit switches active termination
// [R05] clamp codes: auto, 1.5, 0.825, 0.6 Vpp
// [R06] integrator disable bit turns offset integrator off
// [R07] gain codes: 18, 24, 15 dB, 11 reserved
// [R08] per-channel enable selects per-channel gain fields
// [R09] mask bit n powers down channel n+1
// [R10] channel power-down hits active path only
// [R11] low noise figure bit enables low_noise_figure_enable mode
// [R12] power mode: low noise, low, medium, reserved
// [R13] attenuator/post-amp power-down affects those two only
// [R14] input amp power-down affects input amp only
// [R15] partial power-down puts three stages partially down
// [R16] complete power-down wins over partial power-down
// [R17] summing amp feedback field passes to amplifier
// [R18] fast clock type: differential or CMOS
// [R19] per-channel gains from word 0x39, two bits each
// [R20] host writes one 24-clock frame per word
// [R21] host writes zero into reserved fields
// [R22] all fields reset to zero; post-amp 24/30 dB
// [R23] outputs static, decoded on own clock after frame
`include "fgp_consts.svh"

module fgp_front_end_cfg (
	input wire logic clk,
	input wire logic srst,
	input wire logic spi_sclk,
	input wire logic spi_sdata,
	input wire logic spi_sen_n,
	input wire logic doppler_mode,
	output logic post_amp_gain_select,
	output logic term_enable,
	output logic [4:0] term_resistor_map,
	output logic [7:0] term_high_z,
	output fgp_pkg::fgp_clamp_e input_clamp_level,
	output logic input_offset_integrator_off,
	output logic [15:0] input_amp_gain,
	output logic [7:0] imaging_path_power_down,
	output logic [7:0] doppler_path_power_down,
	output logic low_noise_figure_enable,
	output fgp_pkg::fgp_pmode_e power_mode,
	output fgp_pkg::fgp_stage_e input_amp_pwr,
	output fgp_pkg::fgp_stage_e var_attenuator_pwr,
	output fgp_pkg::fgp_stage_e post_amp_pwr,
	output logic [4:0] summing_amp_feedback_select,
	output logic doppler_fast_clock_type
);
	logic wr_valid;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] word_post_amp;
	logic [15:0] word_term;
	logic [15:0] word_power;
	logic [15:0] word_doppler;
	logic [15:0] word_ch_gain;
	fgp_pkg::fgp_dec_s r;
	fgp_pkg::fgp_dec_s next_r;

	// ----------------------------------------------------------------
	// serial port and stored words
	// ----------------------------------------------------------------
	fgp_serial_rx u_rx (
		.clk(clk),
		.srst(srst),
		.spi_sclk(spi_sclk),
		.spi_sdata(spi_sdata),
		.spi_sen_n(spi_sen_n),
		.wr_valid(wr_valid),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	fgp_reg_store u_store (
		.clk(clk),
		.srst(srst),
		.wr_valid(wr_valid),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.word_post_amp(word_post_amp),
		.word_term(word_term),
		.word_power(word_power),
		.word_doppler(word_doppler),
		.word_ch_gain(word_ch_gain)
	);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] ch_gain_code(input logic per_ch_en, input logic [1:0] global_code,
			input logic [15:0] ch_word, input int ch);
		logic [1:0] code;
		code = global_code;
		if (per_ch_en) begin
			code = ch_word[2 * ch +: 2]; // see [R08] see [R19]
		end
		return code;
	endfunction : ch_gain_code

	function automatic logic [4:0] preset_map(input fgp_pkg::fgp_preset_e preset);
		logic [4:0] map;
		map = `FGP_MAP_50;
		unique case (preset) // see [R02]
			fgp_pkg::term_50: map = `FGP_MAP_50;
			fgp_pkg::term_100: map = `FGP_MAP_100;
			fgp_pkg::term_200: map = `FGP_MAP_200;
			fgp_pkg::term_400: map = `FGP_MAP_400;
		endcase
		return map;
	endfunction : preset_map

	// a stage is fully off if the complete bit or its own bit is set, since
	// a full shutdown is deeper than the fast-wake partial state
	function automatic fgp_pkg::fgp_stage_e stage_state(input logic complete, input logic own_off,
			input logic partial);
		fgp_pkg::fgp_stage_e st;
		st = fgp_pkg::stage_on;
		if (complete || own_off) begin
			st = fgp_pkg::stage_off; // see [R16]
		end else if (partial) begin
			st = fgp_pkg::stage_partial; // see [R15]
		end
		return st;
	endfunction : stage_state

	// ----------------------------------------------------------------
	// decode of the stored words
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] gain;
		logic [7:0] mask;
		fgp_pkg::fgp_preset_e preset;
		gain = 2'h0;
		mask = word_power[`FGP_PDN_MASK_HI:`FGP_PDN_MASK_LO];
		preset = fgp_pkg::fgp_preset_e'(word_term[`FGP_TERM_PRESET_HI:`FGP_TERM_PRESET_LO]);
		next_r = r;
		next_r.post_amp_gain_select = word_post_amp[`FGP_POST_AMP_GAIN_BIT]; // see [R22]
		next_r.term_enable = word_term[`FGP_TERM_EN_BIT]; // see [R04]
		if (word_term[`FGP_TERM_IND_EN_BIT]) begin
			next_r.term_resistor_map = word_term[`FGP_TERM_IND_HI:`FGP_TERM_IND_LO]; // see [R01]
		end else begin
			next_r.term_resistor_map = preset_map(preset); // see [R02]
		end
		for (int ch = 0; ch < `FGP_NUM_CH; ch++) begin
			gain = ch_gain_code(word_term[`FGP_PER_CH_EN_BIT], word_term[`FGP_GAIN_HI:`FGP_GAIN_LO],
				word_ch_gain, ch); // see [R07]
			next_r.input_amp_gain[ch] = gain;
			// 50 ohm is not available at 15 dB, so that code falls back to high impedance
			next_r.term_high_z[ch] = (gain == fgp_pkg::gain_15db) && (preset == fgp_pkg::term_50); // see [R03]
		end
		next_r.input_clamp_level = fgp_pkg::fgp_clamp_e'(word_term[`FGP_CLAMP_HI:`FGP_CLAMP_LO]); // see [R05]
		next_r.input_offset_integrator_off = word_term[`FGP_INTEG_OFF_BIT]; // see [R06]
		if (doppler_mode) begin
			next_r.imaging_path_power_down = 8'h00; // see [R10]
			next_r.doppler_path_power_down = mask; // see [R09]
		end else begin
			next_r.imaging_path_power_down = mask; // see [R09]
			next_r.doppler_path_power_down = 8'h00; // see [R10]
		end
		next_r.low_noise_figure_enable = word_power[`FGP_LOW_NOISE_FIGURE_ENABLE_BIT]; // see [R11]
		next_r.power_mode = fgp_pkg::fgp_pmode_e'(word_power[`FGP_PMODE_HI:`FGP_PMODE_LO]); // see [R12]
		next_r.input_amp_pwr = stage_state(word_power[`FGP_COMPLETE_BIT], word_power[`FGP_AMP_PDN_BIT],
			word_power[`FGP_PARTIAL_BIT]); // see [R14]
		next_r.var_attenuator_pwr = stage_state(word_power[`FGP_COMPLETE_BIT], word_power[`FGP_ATT_PDN_BIT],
			word_power[`FGP_PARTIAL_BIT]); // see [R13]
		next_r.post_amp_pwr = stage_state(word_power[`FGP_COMPLETE_BIT], word_power[`FGP_ATT_PDN_BIT],
			word_power[`FGP_PARTIAL_BIT]); // see [R13]
		next_r.summing_amp_feedback_select = word_doppler[`FGP_SUM_FB_HI:`FGP_SUM_FB_LO]; // see [R17]
		next_r.doppler_fast_clock_type = word_doppler[`FGP_FAST_CLK_BIT]; // see [R18]
	end

	// decoded outputs hold between writes, except the path power-downs, which also follow doppler_mode; changes land one clock after the store
	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0; // see [R22]
		end else begin
			r <= next_r; // see [R23]
		end
	end

	assign post_amp_gain_select = r.post_amp_gain_select;
	assign term_enable = r.term_enable;
	assign term_resistor_map = r.term_resistor_map;
	assign term_high_z = r.term_high_z;
	assign input_clamp_level = r.input_clamp_level;
	assign input_offset_integrator_off = r.input_offset_integrator_off;
	assign input_amp_gain = r.input_amp_gain;
	assign imaging_path_power_down = r.imaging_path_power_down;
	assign doppler_path_power_down = r.doppler_path_power_down;
	assign low_noise_figure_enable = r.low_noise_figure_enable;
	assign power_mode = r.power_mode;
	assign input_amp_pwr = r.input_amp_pwr;
	assign var_attenuator_pwr = r.var_attenuator_pwr;
	assign post_amp_pwr = r.post_amp_pwr;
	assign summing_amp_feedback_select = r.summing_amp_feedback_select;
	assign doppler_fast_clock_type = r.doppler_fast_clock_type;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_power_write;
		wr_valid && wr_addr == `FGP_ADDR_POWER;
	endsequence

	sequence s_quiet;
		!wr_valid [*3];
	endsequence

	property p_ind_gate;
		!word_term[`FGP_TERM_IND_EN_BIT] |=> term_resistor_map == preset_map(
			fgp_pkg::fgp_preset_e'($past(word_term[`FGP_TERM_PRESET_HI:`FGP_TERM_PRESET_LO])));
	endproperty
	a_ind_gate: assert property (p_ind_gate) else $error("individual resistor field leaked while disabled"); // see [R01]

	property p_ind_use;
		word_term[`FGP_TERM_IND_EN_BIT] |=> term_resistor_map == $past(word_term[4:0]);
	endproperty
	a_ind_use: assert property (p_ind_use) else $error("individual resistor field not applied"); // see [R01]

	property p_high_z;
		word_term[`FGP_TERM_PRESET_HI:`FGP_TERM_PRESET_LO] == 2'h0 && !word_term[`FGP_PER_CH_EN_BIT]
			&& word_term[`FGP_GAIN_HI:`FGP_GAIN_LO] == 2'h2 |=> term_high_z == 8'hff;
	endproperty
	a_high_z: assert property (p_high_z) else $error("no high impedance at 15 dB with preset 00"); // see [R03]

	property p_term_en;
		##1 term_enable == $past(word_term[`FGP_TERM_EN_BIT]);
	endproperty
	a_term_en: assert property (p_term_en) else $error("termination enable does not follow its bit"); // see [R04]

	property p_per_ch_gain;
		word_term[`FGP_PER_CH_EN_BIT] |=> input_amp_gain == $past(word_ch_gain);
	endproperty
	a_per_ch_gain: assert property (p_per_ch_gain) else $error("per-channel gains not applied"); // see [R08]

	property p_global_gain;
		!word_term[`FGP_PER_CH_EN_BIT] |=> input_amp_gain == {8{$past(word_term[`FGP_GAIN_HI:`FGP_GAIN_LO])}};
	endproperty
	a_global_gain: assert property (p_global_gain) else $error("global gain not applied to every channel"); // see [R07]

	property p_path_pdn;
		doppler_mode |=> doppler_path_power_down == $past(word_power[7:0]) && imaging_path_power_down == 8'h00;
	endproperty
	a_path_pdn: assert property (p_path_pdn) else $error("doppler mode power-down on wrong path"); // see [R10]

	property p_complete_wins;
		word_power[`FGP_COMPLETE_BIT] |=> input_amp_pwr == fgp_pkg::stage_off
			&& var_attenuator_pwr == fgp_pkg::stage_off && post_amp_pwr == fgp_pkg::stage_off;
	endproperty
	a_complete_wins: assert property (p_complete_wins) else $error("complete power-down did not win"); // see [R16]

	property p_partial;
		word_power[15:12] == 4'h4 |=> input_amp_pwr == fgp_pkg::stage_partial
			&& post_amp_pwr == fgp_pkg::stage_partial;
	endproperty
	a_partial: assert property (p_partial) else $error("partial power-down not applied"); // see [R15]

	property p_amp_only;
		word_power[15:12] == 4'h2 |=> input_amp_pwr == fgp_pkg::stage_off && post_amp_pwr == fgp_pkg::stage_on;
	endproperty
	a_amp_only: assert property (p_amp_only) else $error("input amp power-down reached other stages"); // see [R14]

	property p_write_to_output;
		s_power_write ##2 !wr_valid |=> power_mode == fgp_pkg::fgp_pmode_e'($past(wr_data[11:10], 3));
	endproperty
	a_write_to_output: assert property (p_write_to_output) else $error("power mode late after write"); // see [R12]

	property p_hold;
		s_quiet |-> $stable(term_enable) && $stable(power_mode) && $stable(summing_amp_feedback_select);
	endproperty
	a_hold: assert property (p_hold) else $error("control output moved without a write"); // see [R23]

	property p_clamp;
		##1 input_clamp_level == fgp_pkg::fgp_clamp_e'($past(word_term[`FGP_CLAMP_HI:`FGP_CLAMP_LO]));
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp level does not follow its field"); // see [R05]

	property p_integ;
		##1 input_offset_integrator_off == $past(word_term[`FGP_INTEG_OFF_BIT]);
	endproperty
	a_integ: assert property (p_integ) else $error("integrator disable does not follow its bit"); // see [R06]

	property p_img_pdn;
		!doppler_mode |=> imaging_path_power_down == $past(word_power[`FGP_PDN_MASK_HI:`FGP_PDN_MASK_LO])
			&& doppler_path_power_down == 8'h00;
	endproperty
	a_img_pdn: assert property (p_img_pdn) else $error("imaging mode power-down on wrong path"); // see [R09]

	property p_low_noise_figure_enable;
		##1 low_noise_figure_enable == $past(word_power[`FGP_LOW_NOISE_FIGURE_ENABLE_BIT]);
	endproperty
	a_low_noise_figure_enable: assert property (p_low_noise_figure_enable) else $error("low noise figure does not follow its bit"); // see [R11]

	property p_atten_only;
		word_power[15:12] == 4'h1 |=> input_amp_pwr == fgp_pkg::stage_on
			&& var_attenuator_pwr == fgp_pkg::stage_off && post_amp_pwr == fgp_pkg::stage_off;
	endproperty
	a_atten_only: assert property (p_atten_only) else $error("attenuator power-down reached input amp"); // see [R13]

	property p_doppler_fields;
		##1 summing_amp_feedback_select == $past(word_doppler[`FGP_SUM_FB_HI:`FGP_SUM_FB_LO])
			&& doppler_fast_clock_type == $past(word_doppler[`FGP_FAST_CLK_BIT]);
	endproperty
	a_doppler_fields: assert property (p_doppler_fields) else $error("doppler clock fields not applied"); // see [R17] [R18]

	property p_post_gain;
		##1 post_amp_gain_select == $past(word_post_amp[`FGP_POST_AMP_GAIN_BIT]);
	endproperty
	a_post_gain: assert property (p_post_gain) else $error("post amp gain does not follow its bit"); // see [R22]
endmodule : fgp_front_end_cfg

// file: fgp_host_model.sv
// ----------------------------------------------------------------
// host side of the serial programming port
// ----------------------------------------------------------------
module fgp_host_model (
	input wire logic clk,
	output logic spi_sclk,
	output logic spi_sdata,
	output logic spi_sen_n
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		spi_sclk = 1'b0;
		spi_sdata = 1'b0;
		spi_sen_n = 1'b1;
	end

	// one whole-word frame, msb first; ph is the clk count of each sclk phase
	task automatic send(input logic [7:0] addr, input logic [15:0] data, input int ph);
		logic [23:0] frame;
		frame = {addr, data};
		@(posedge clk);
		spi_sen_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdata <= frame[i];
			spi_sclk <= 1'b0;
			repeat (ph) @(posedge clk);
			spi_sclk <= 1'b1;
			repeat (ph) @(posedge clk);
		end
		spi_sclk <= 1'b0;
		// released data line must not look like a held bit
		spi_sdata <= ~frame[0];
		repeat (ph) @(posedge clk);
		spi_sen_n <= 1'b1;
		// callers keep reserved fields zero; gap covers decode latency
		repeat (12) @(posedge clk);
	endtask : send
endmodule : fgp_host_model

// file: tb_front_end_gain_power_config_regs.sv
module tb_front_end_gain_power_config_regs;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk;
	logic srst;
	logic doppler_mode;
	logic spi_sclk;
	logic spi_sdata;
	logic spi_sen_n;
	logic post_amp_gain_select;
	logic term_enable;
	logic [4:0] term_resistor_map;
	logic [7:0] term_high_z;
	fgp_pkg::fgp_clamp_e input_clamp_level;
	logic input_offset_integrator_off;
	logic [15:0] input_amp_gain;
	logic [7:0] imaging_path_power_down;
	logic [7:0] doppler_path_power_down;
	logic low_noise_figure_enable;
	fgp_pkg::fgp_pmode_e power_mode;
	fgp_pkg::fgp_stage_e input_amp_pwr;
	fgp_pkg::fgp_stage_e var_attenuator_pwr;
	fgp_pkg::fgp_stage_e post_amp_pwr;
	logic [4:0] summing_amp_feedback_select;
	logic doppler_fast_clock_type;
	int fail_count = 0;
	int num_checks = 0;
	logic [1:0] c;
	logic [15:0] stage_cmd [4] = '{16'h1000, 16'h2000, 16'h4000, 16'hc000};
	logic [5:0] stage_exp [4] = '{6'h0a, 6'h20, 6'h15, 6'h2a};
	logic [5:0] stages_seen;

	assign stages_seen = {input_amp_pwr, var_attenuator_pwr, post_amp_pwr};

	fgp_host_model host (.clk(clk), .spi_sclk(spi_sclk), .spi_sdata(spi_sdata), .spi_sen_n(spi_sen_n));

	fgp_front_end_cfg uut (
		.clk(clk), .srst(srst), .spi_sclk(spi_sclk), .spi_sdata(spi_sdata), .spi_sen_n(spi_sen_n),
		.doppler_mode(doppler_mode), .post_amp_gain_select(post_amp_gain_select), .term_enable(term_enable),
		.term_resistor_map(term_resistor_map), .term_high_z(term_high_z), .input_clamp_level(input_clamp_level),
		.input_offset_integrator_off(input_offset_integrator_off), .input_amp_gain(input_amp_gain),
		.imaging_path_power_down(imaging_path_power_down), .doppler_path_power_down(doppler_path_power_down),
		.low_noise_figure_enable(low_noise_figure_enable), .power_mode(power_mode), .input_amp_pwr(input_amp_pwr),
		.var_attenuator_pwr(var_attenuator_pwr), .post_amp_pwr(post_amp_pwr),
		.summing_amp_feedback_select(summing_amp_feedback_select), .doppler_fast_clock_type(doppler_fast_clock_type)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		host.send(addr, data, 4);
	endtask : wr

	task automatic check_zero();
		check_val("post_amp", 16'h0000, {15'h0000, post_amp_gain_select});
		// preset code 00 decodes to the 50 ohm map once the first decode has run
		check_val("term_map", 16'h0001, {11'h000, term_resistor_map});
		check_val("gain", 16'h0000, input_amp_gain);
		check_val("stages", 16'h0000, {10'h000, stages_seen});
		check_val("sum_fb", 16'h0000, {10'h000, doppler_fast_clock_type, summing_amp_feedback_select});
	endtask : check_zero

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		srst <= 1'b1;
		doppler_mode <= 1'b0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		check_zero();
		host.send(8'h33, 16'h2000, 9);
		check_val("post_amp", 16'h0001, {15'h0000, post_amp_gain_select});
		// word outside this bank must leave everything alone
		wr(8'h37, 16'hffff);
		check_val("post_amp", 16'h0001, {15'h0000, post_amp_gain_select});
		check_val("gain", 16'h0000, input_amp_gain);
		for (int p = 0; p < 4; p++) begin
			wr(8'h34, 16'h0100 | (16'(p) << 6));
			check_val("term_map", 16'h0001 << p, {11'h000, term_resistor_map});
			check_val("term_en", 16'h0001, {15'h0000, term_enable});
			check_val("high_z", 16'h0000, {8'h00, term_high_z});
		end
		wr(8'h34, 16'h00b5);
		check_val("term_map", 16'h0015, {11'h000, term_resistor_map});
		check_val("term_en", 16'h0000, {15'h0000, term_enable});
		wr(8'h34, 16'h0095);
		check_val("term_map", 16'h0004, {11'h000, term_resistor_map});
		for (int g = 0; g < 3; g++) begin
			c = 2'(g);
			wr(8'h34, 16'(g) << 13);
			check_val("gain", {8{c}}, input_amp_gain);
			check_val("high_z", (g == 2) ? 16'h00ff : 16'h0000, {8'h00, term_high_z});
		end
		wr(8'h34, 16'h4040);
		check_val("high_z", 16'h0000, {8'h00, term_high_z});
		check_val("term_map", 16'h0002, {11'h000, term_resistor_map});
		for (int k = 0; k < 4; k++) begin
			wr(8'h34, (16'(k) << 9) | ((k % 2 == 1) ? 16'h1000 : 16'h0000));
			check_val("clamp", 16'(k), {14'h0000, input_clamp_level});
			check_val("integ_off", 16'(k % 2), {15'h0000, input_offset_integrator_off});
		end
		wr(8'h39, 16'h8612);
		check_val("gain", 16'h0000, input_amp_gain);
		wr(8'h34, 16'h8000);
		check_val("gain", 16'h8612, input_amp_gain);
		check_val("high_z", 16'h0091, {8'h00, term_high_z});
		wr(8'h34, 16'hc000);
		check_val("gain", 16'h8612, input_amp_gain);
		wr(8'h35, 16'h02a5);
		check_val("img_pdn", 16'h00a5, {8'h00, imaging_path_power_down});
		check_val("dop_pdn", 16'h0000, {8'h00, doppler_path_power_down});
		check_val("low_noise_figure_enable", 16'h0001, {15'h0000, low_noise_figure_enable});
		doppler_mode <= 1'b1;
		repeat (3) @(posedge clk);
		check_val("img_pdn", 16'h0000, {8'h00, imaging_path_power_down});
		check_val("dop_pdn", 16'h00a5, {8'h00, doppler_path_power_down});
		doppler_mode <= 1'b0;
		for (int m = 0; m < 3; m++) begin
			wr(8'h35, 16'(m) << 10);
			check_val("pmode", 16'(m), {14'h0000, power_mode});
			check_val("low_noise_figure_enable", 16'h0000, {15'h0000, low_noise_figure_enable});
		end
		for (int s = 0; s < 4; s++) begin
			wr(8'h35, stage_cmd[s]);
			check_val("stages", {10'h000, stage_exp[s]}, {10'h000, stages_seen});
		end
		wr(8'h35, 16'h0000);
		check_val("stages", 16'h0000, {10'h000, stages_seen});
		wr(8'h36, 16'h0033);
		check_val("sum_fb", 16'h0033, {10'h000, doppler_fast_clock_type, summing_amp_feedback_select});
		wr(8'h36, 16'h000c);
		check_val("sum_fb", 16'h000c, {10'h000, doppler_fast_clock_type, summing_amp_feedback_select});
		// second reset in mid-run clears every field again
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		check_zero();
		final_report();
	end
endmodule : tb_front_end_gain_power_config_regs
